/* File: hw/drta_pkg.sv */
// package of constants for the debug discovery table and access block
package drta_pkg;

  // ********************************************************
  // address map
  // ********************************************************
  localparam logic [31:0] DRTA_PPB_LO = 32'he000_0000;
  localparam logic [31:0] DRTA_PPB_HI = 32'he010_0000;
  localparam logic [31:0] DRTA_ROM_BASE = 32'he00f_f000;
  localparam logic [31:0] DRTA_ROM_LAST = 32'he00f_fffc;
  localparam logic [31:0] DRTA_HCSR_ADDR = 32'he000_edf0;
  localparam logic [31:0] DRTA_CRDR_ADDR = 32'he000_edf8;
  localparam logic [31:0] DRTA_EMCR_ADDR = 32'he000_edfc;

  // ********************************************************
  // table offsets and entry values
  // ********************************************************
  localparam logic [11:0] DRTA_OFS_SCS = 12'h000;
  localparam logic [11:0] DRTA_OFS_WATCH = 12'h004;
  localparam logic [11:0] DRTA_OFS_BREAK = 12'h008;
  localparam logic [11:0] DRTA_OFS_END = 12'h00c;
  localparam logic [31:0] DRTA_ENT_SCS = 32'hfff0_f003;
  localparam logic [31:0] DRTA_ENT_WATCH = 32'hfff0_2002;
  localparam logic [31:0] DRTA_ENT_BREAK = 32'hfff0_3002;
  localparam logic [31:0] DRTA_ENT_END = 32'h0000_0000;
  localparam int DRTA_FMT_BIT = 1;
  localparam int DRTA_PRESENT_BIT = 0;

  // ********************************************************
  // control register fields and reset values
  // ********************************************************
  localparam logic [15:0] DRTA_HCSR_KEY = 16'ha05f;
  localparam int DRTA_HCSR_EN_BIT = 0;
  localparam int DRTA_HCSR_HALT_BIT = 1;
  localparam int DRTA_HCSR_SHALT_BIT = 17;
  localparam int DRTA_EMCR_WEN_BIT = 24;
  localparam logic [31:0] DRTA_RST_ZERO = 32'h0000_0000;

  // ********************************************************
  // access port answers
  // ********************************************************
  typedef enum logic [2:0] {
    DRTA_RESP_OKAY = 3'b001,
    DRTA_RESP_ERR = 3'b010,
    DRTA_RESP_FAULT = 3'b100
  } drta_resp_type;

endpackage

/* File: hw/drta_top.sv */
// discovery table, debug region access checks and halt control
//
// Behaviour
// - only full word accesses; narrower ones get an error answer.
// - register data is always little-endian, regardless of core endianness; the code byte-swaps non-debug-port accesses when the core is big-endian.
// - region accesses complete one at a time in order, never merged.
// - unprivileged region accesses are blocked and raise the fatal fault.
// - unassigned region addresses have no function and read zero.
// - entry bits 31:12 hold a signed offset, bits 11:2 zero.
// - entry bit 1 reads one, marking the 32-bit format.
// - entry bit 0 marks a present component; others are null.
// - all offsets negative; an all-zero word ends the table.
// - offset 0x000 reads 0xfff0f003 for the system control space.
// - offset 0x004 reads watch entry, bit 0 set when fitted.
// - offset 0x008 reads break entry, bit 0 set when fitted.
// - offset 0x00c holds the zero terminator.
// - unused table words 0x010 to 0xffc read zero.
// - the table answers only debug access port requests.
// - the access port base register gives the table address.
// - halt request write halts; halted status bit then reads one.
// - debug port writes are accepted while software runs.
// - halt by register, external request, breakpoint or debug event.
// - core registers reachable from the debugger only while halted.
// - debug events halt only when halting debug enable is one.
`timescale 1ns/1ps

module drta_top
  import drta_pkg::*;
#(
  parameter bit WATCH_FITTED = 1'b1,
  parameter bit BREAK_FITTED = 1'b1
)(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // access port request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  input wire logic [2:0] req_size_i,
  input wire logic req_from_dap_i,
  input wire logic req_priv_i,
  input wire logic core_big_endian_i,
  // access port answer
  output logic resp_valid_o,
  output logic [31:0] resp_rdata_o,
  output drta_pkg::drta_resp_type resp_code_o,
  output logic [31:0] ap_base_o,
  // core side
  input wire logic ext_debug_req_i,
  input wire logic break_instr_i,
  input wire logic debug_event_i,
  input wire logic [31:0] core_reg_rdata_i,
  output logic core_reg_we_o,
  output logic [31:0] core_reg_wdata_o,
  output logic fatal_fault_o,
  output logic halted_o,
  output logic halting_debug_enable_o,
  output logic watch_unit_enable_o
);

  // ********************************************************
  // decoding
  // ********************************************************
  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  logic [31:0] ext_q;
  logic [31:0] ext_sync_q;
  logic ext_req;
  logic in_ppb;
  logic is_word;
  logic blocked;
  logic bad_size;
  logic in_rom;
  logic [11:0] rom_ofs;
  logic take;
  logic [31:0] rdata;
  logic [31:0] bus_wdata;
  logic halting_debug_enable_q;
  logic halted_q;
  logic watch_unit_enable_q;
  logic [31:0] core_reg_buf_q;

  assign in_ppb = (req_addr_i >= DRTA_PPB_LO) && (req_addr_i < DRTA_PPB_HI);
  assign is_word = (req_size_i == 3'h2) && (req_addr_i[1:0] == 2'h0);
  assign take = req_valid_i && in_ppb;
  assign blocked = take && !req_priv_i;
  assign bad_size = take && req_priv_i && !is_word;
  assign in_rom = in_range(req_addr_i, DRTA_ROM_BASE, DRTA_ROM_LAST)
                  && req_from_dap_i;
  assign rom_ofs = req_addr_i[11:0];
  assign ap_base_o = DRTA_ROM_BASE;
  // byte swap undone when core writes big-endian
  assign bus_wdata = (core_big_endian_i && !req_from_dap_i) ?
                     {<<8{req_wdata_i}} : req_wdata_i;

  // ********************************************************
  // read mux
  // ********************************************************
  always_comb
  begin
    rdata = DRTA_RST_ZERO;
    if (in_rom && rom_ofs == DRTA_OFS_SCS)
    begin
      rdata = DRTA_ENT_SCS;
    end
    else if (in_rom && rom_ofs == DRTA_OFS_WATCH)
    begin
      rdata = DRTA_ENT_WATCH | {31'h0, WATCH_FITTED};
    end
    else if (in_rom && rom_ofs == DRTA_OFS_BREAK)
    begin
      rdata = DRTA_ENT_BREAK | {31'h0, BREAK_FITTED};
    end
    else if (in_rom && rom_ofs == DRTA_OFS_END)
    begin
      rdata = DRTA_ENT_END;
    end
    else if (in_rom)
    begin
      rdata = DRTA_RST_ZERO;
    end
    else if (req_addr_i == DRTA_HCSR_ADDR)
    begin
      rdata = DRTA_RST_ZERO;
      rdata[DRTA_HCSR_EN_BIT] = halting_debug_enable_q;
      rdata[DRTA_HCSR_SHALT_BIT] = halted_q;
    end
    else if (req_addr_i == DRTA_EMCR_ADDR)
    begin
      rdata = DRTA_RST_ZERO;
      rdata[DRTA_EMCR_WEN_BIT] = watch_unit_enable_q;
    end
    else if (req_addr_i == DRTA_CRDR_ADDR && halted_q)
    begin
      rdata = core_reg_rdata_i;
    end
  end

  // ********************************************************
  // answer, one access at a time
  // ********************************************************
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      resp_valid_o <= 1'b0;
      resp_rdata_o <= DRTA_RST_ZERO;
      resp_code_o <= DRTA_RESP_OKAY;
      fatal_fault_o <= 1'b0;
    end
    else
    begin
      resp_valid_o <= take;
      fatal_fault_o <= blocked;
      resp_rdata_o <= DRTA_RST_ZERO;
      resp_code_o <= DRTA_RESP_OKAY;
      if (blocked)
      begin
        resp_code_o <= DRTA_RESP_FAULT;
      end
      else if (bad_size)
      begin
        resp_code_o <= DRTA_RESP_ERR;
      end
      else if (take && !req_write_i)
      begin
        resp_rdata_o <= (core_big_endian_i && !req_from_dap_i) ?
                        {<<8{rdata}} : rdata;
      end
    end
  end

  // ********************************************************
  // halt control
  // ********************************************************
  logic wr_ok;
  logic wr_hcsr;
  logic wr_emcr;
  assign wr_ok = take && req_write_i && req_priv_i && is_word;
  assign wr_hcsr = wr_ok && req_addr_i == DRTA_HCSR_ADDR
                   && bus_wdata[31:16] == DRTA_HCSR_KEY;
  assign wr_emcr = wr_ok && req_addr_i == DRTA_EMCR_ADDR;

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ext_q <= DRTA_RST_ZERO;
      ext_sync_q <= DRTA_RST_ZERO;
    end
    else
    begin
      ext_q <= {31'h0, ext_debug_req_i};
      ext_sync_q <= ext_q;
    end
  end
  assign ext_req = ext_sync_q[0];

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      halting_debug_enable_q <= 1'b0;
      watch_unit_enable_q <= 1'b0;
    end
    else
    begin
      if (wr_hcsr)
      begin
        halting_debug_enable_q <= bus_wdata[DRTA_HCSR_EN_BIT];
      end
      if (wr_emcr)
      begin
        watch_unit_enable_q <= bus_wdata[DRTA_EMCR_WEN_BIT];
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      halted_q <= 1'b0;
    end
    else if (!halting_debug_enable_q)
    begin
      halted_q <= 1'b0;
    end
    else if ((wr_hcsr && bus_wdata[DRTA_HCSR_HALT_BIT]) || ext_req
             || break_instr_i || debug_event_i)
    begin
      halted_q <= 1'b1;
    end
    else if (wr_hcsr && halted_q && bus_wdata[DRTA_HCSR_EN_BIT])
    begin
      halted_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      core_reg_we_o <= 1'b0;
      core_reg_buf_q <= DRTA_RST_ZERO;
    end
    else
    begin
      core_reg_we_o <= wr_ok && req_addr_i == DRTA_CRDR_ADDR
                       && halted_q;
      if (wr_ok && req_addr_i == DRTA_CRDR_ADDR)
      begin
        core_reg_buf_q <= bus_wdata;
      end
    end
  end

  assign core_reg_wdata_o = core_reg_buf_q;
  assign halted_o = halted_q;
  assign halting_debug_enable_o = halting_debug_enable_q;
  assign watch_unit_enable_o = watch_unit_enable_q;

  // ********************************************************
  // checks
  // ********************************************************
  property p_fault;
    @(posedge clock_i) disable iff (!reset_n_i)
    (req_valid_i && in_ppb && !req_priv_i) |=> fatal_fault_o
      && resp_code_o == DRTA_RESP_FAULT;
  endproperty
  a_fault: assert property (p_fault) else $error("no fault");

  property p_size;
    @(posedge clock_i) disable iff (!reset_n_i)
    (take && req_priv_i && !is_word) |=> resp_code_o == DRTA_RESP_ERR;
  endproperty
  a_size: assert property (p_size) else $error("narrow ok");

  property p_scs;
    @(posedge clock_i) disable iff (!reset_n_i)
    (take && req_priv_i && is_word && !req_write_i && req_from_dap_i
     && req_addr_i == DRTA_ROM_BASE)
    |=> resp_rdata_o == DRTA_ENT_SCS;
  endproperty
  a_scs: assert property (p_scs) else $error("bad scs entry");

  property p_end;
    @(posedge clock_i) disable iff (!reset_n_i)
    (take && req_priv_i && is_word && !req_write_i && req_from_dap_i
     && req_addr_i == DRTA_ROM_BASE + 32'hc)
    |=> resp_rdata_o == DRTA_RST_ZERO;
  endproperty
  a_end: assert property (p_end) else $error("no terminator");

  property p_resp;
    @(posedge clock_i) disable iff (!reset_n_i)
    take |=> resp_valid_o;
  endproperty
  a_resp: assert property (p_resp) else $error("no answer");

  property p_gate;
    @(posedge clock_i) disable iff (!reset_n_i)
    !halting_debug_enable_q |=> !halted_q;
  endproperty
  a_gate: assert property (p_gate) else $error("halt w/o en");

  property p_halt;
    @(posedge clock_i) disable iff (!reset_n_i)
    (halting_debug_enable_q && (break_instr_i || debug_event_i)
     && !(wr_hcsr && !bus_wdata[DRTA_HCSR_EN_BIT])) |=> halted_o;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt");

  property p_core;
    @(posedge clock_i) disable iff (!reset_n_i)
    core_reg_we_o |-> $past(halted_q);
  endproperty
  a_core: assert property (p_core) else $error("core wr running");

  c_halt: cover property (@(posedge clock_i) $rose(halted_q));
  c_fault: cover property (@(posedge clock_i) fatal_fault_o);
  c_core: cover property (@(posedge clock_i) core_reg_we_o);

endmodule // drta_top

/* File: verif/drta_host_model.sv */
// debugger-side model issuing access port requests
`timescale 1ns/1ps

module drta_host_model
  import drta_pkg::*;
(
  // clock
  input wire logic clock_i,
  // request
  output logic req_valid_o,
  output logic req_write_o,
  output logic [31:0] req_addr_o,
  output logic [31:0] req_wdata_o,
  output logic [2:0] req_size_o,
  output logic req_from_dap_o,
  output logic req_priv_o,
  // answer
  input wire logic resp_valid_i,
  input wire logic [31:0] resp_rdata_i,
  input wire drta_pkg::drta_resp_type resp_code_i
);
  initial
  begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_addr_o = 32'h0;
    req_wdata_o = 32'h0;
    req_size_o = 3'h2;
    req_from_dap_o = 1'b1;
    req_priv_o = 1'b1;
  end

  // one access, answer taken one edge after the request
  task automatic access(input logic w, input logic [31:0] a, d,
                        input logic [2:0] s, input logic debug_access_port, pv,
                        output logic [31:0] rd, output drta_resp_type rc,
                        output logic seen);
    @(posedge clock_i);
    #1;
    req_valid_o = 1'b1;
    req_write_o = w;
    req_addr_o = a;
    req_wdata_o = d;
    req_size_o = s;
    req_from_dap_o = debug_access_port;
    req_priv_o = pv;
    @(posedge clock_i);
    #1;
    seen = resp_valid_i;
    rd = resp_rdata_i;
    rc = resp_code_i;
    req_valid_o = 1'b0;
    // released lines must not keep the old value
    req_addr_o = ~a;
    req_wdata_o = ~d;
  endtask
endmodule // drta_host_model

/* File: verif/drta_top_tb.sv */
// self-checking bench for the discovery table and access block
`timescale 1ns/1ps

module drta_top_tb;
  import drta_pkg::*;
  typedef struct {
    logic [31:0] addr;
    logic [2:0] size;
    logic debug_access_port;
    logic priv;
    logic be;
    logic [31:0] data;
    drta_resp_type code;
  } drta_row_type;
  logic clock_i, reset_n_i, be, brk, dbg, seen;
  logic rv, rw, rdap, rpriv, rsv, hlt, hde, wen;
  logic ext, ff, cwe;
  logic [31:0] cwd;
  logic [31:0] ra, rwd, rrd, base, rd;
  logic [31:0] core_rd = 32'h0bad_f00d;
  logic [2:0] rs;
  drta_resp_type rcode, rc;
  int n_fail = 0;
  int samples_checked = 0;
  drta_row_type rows [11];
  localparam logic [31:0] KEY = {DRTA_HCSR_KEY, 16'h0};

  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  drta_host_model i_drta_host_model (.clock_i(clock_i), .req_valid_o(rv),
    .req_write_o(rw), .req_addr_o(ra), .req_wdata_o(rwd), .req_size_o(rs),
    .req_from_dap_o(rdap), .req_priv_o(rpriv), .resp_valid_i(rsv),
    .resp_rdata_i(rrd), .resp_code_i(rcode));

  drta_top i_drta_top (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .req_valid_i(rv), .req_write_i(rw), .req_addr_i(ra), .req_wdata_i(rwd),
    .req_size_i(rs), .req_from_dap_i(rdap), .req_priv_i(rpriv),
    .core_big_endian_i(be), .resp_valid_o(rsv), .resp_rdata_o(rrd),
    .resp_code_o(rcode), .ap_base_o(base), .ext_debug_req_i(ext),
    .break_instr_i(brk), .debug_event_i(dbg), .core_reg_rdata_i(core_rd),
    .core_reg_we_o(cwe), .core_reg_wdata_o(cwd), .fatal_fault_o(ff),
    .halted_o(hlt), .halting_debug_enable_o(hde), .watch_unit_enable_o(wen));

  task automatic check(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic acc(logic w, logic [31:0] a, d, logic [2:0] s = 3'h2);
    i_drta_host_model.access(w, a, d, s, 1'b1, 1'b1, rd, rc, seen);
  endtask

  task automatic wait_halt(input logic exp);
    for (int i = 0; i < 8 && hlt !== exp; i++)
    begin
      @(posedge clock_i);
      #1;
    end
    check({31'h0, hlt}, {31'h0, exp});
    if (hlt !== exp)
      finish_test;
  endtask

  initial
  begin
    reset_n_i = 1'b0;
    be = 1'b0;
    brk = 1'b0;
    dbg = 1'b0;
    ext = 1'b0;
    rows = '{
      '{DRTA_ROM_BASE, 3'h2, 1, 1, 0, DRTA_ENT_SCS, DRTA_RESP_OKAY},
      '{DRTA_ROM_BASE + 4, 3'h2, 1, 1, 0, 32'hfff0_2003, DRTA_RESP_OKAY},
      '{DRTA_ROM_BASE + 8, 3'h2, 1, 1, 0, 32'hfff0_3003, DRTA_RESP_OKAY},
      '{DRTA_ROM_BASE + 12, 3'h2, 1, 1, 0, 32'h0, DRTA_RESP_OKAY},
      '{DRTA_ROM_BASE + 16, 3'h2, 1, 1, 0, 32'h0, DRTA_RESP_OKAY},
      '{DRTA_ROM_LAST, 3'h2, 1, 1, 0, 32'h0, DRTA_RESP_OKAY},
      '{DRTA_ROM_BASE, 3'h2, 1, 1, 1, DRTA_ENT_SCS, DRTA_RESP_OKAY},
      '{DRTA_ROM_BASE, 3'h0, 1, 1, 0, 32'h0, DRTA_RESP_ERR},
      '{DRTA_ROM_BASE, 3'h2, 1, 0, 0, 32'h0, DRTA_RESP_FAULT},
      '{DRTA_ROM_BASE, 3'h2, 0, 1, 0, 32'h0, DRTA_RESP_OKAY},
      '{DRTA_PPB_LO + 16, 3'h2, 1, 1, 0, 32'h0, DRTA_RESP_OKAY}};
    repeat (6) @(posedge clock_i);
    #1;
    reset_n_i = 1'b1;
    check(base, DRTA_ROM_BASE);
    foreach (rows[k])
    begin
      be = rows[k].be;
      i_drta_host_model.access(1'b0, rows[k].addr, 32'h0, rows[k].size,
        rows[k].debug_access_port, rows[k].priv, rd, rc, seen);
      check(rd, rows[k].data);
      check({29'h0, rc}, {29'h0, rows[k].code});
      check({31'h0, seen}, 32'h1);
      check({31'h0, ff}, {31'h0, rows[k].code == DRTA_RESP_FAULT});
    end
    acc(1'b0, DRTA_PPB_HI, 32'h0);
    check({31'h0, seen}, 32'h0);
    acc(1'b0, DRTA_CRDR_ADDR, 32'h0);
    check(rd, 32'h0);
    acc(1'b1, DRTA_CRDR_ADDR, 32'h1234_5678);
    check({31'h0, cwe}, 32'h0);
    @(posedge clock_i);
    #1;
    dbg = 1'b1;
    @(posedge clock_i);
    #1;
    dbg = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    check({31'h0, hlt}, 32'h0);
    acc(1'b1, DRTA_EMCR_ADDR, 32'h1 << DRTA_EMCR_WEN_BIT);
    check({31'h0, wen}, 32'h1);
    acc(1'b1, DRTA_HCSR_ADDR, KEY | 32'h1);
    check({31'h0, hde}, 32'h1);
    acc(1'b1, DRTA_HCSR_ADDR, KEY | 32'h3);
    wait_halt(1'b1);
    acc(1'b0, DRTA_HCSR_ADDR, 32'h0);
    check({31'h0, rd[DRTA_HCSR_SHALT_BIT]}, 32'h1);
    acc(1'b0, DRTA_CRDR_ADDR, 32'h0);
    check(rd, core_rd);
    acc(1'b1, DRTA_CRDR_ADDR, 32'h5a5a_a5a5);
    check({31'h0, cwe}, 32'h1);
    check(cwd, 32'h5a5a_a5a5);
    acc(1'b1, DRTA_HCSR_ADDR, KEY | 32'h1);
    wait_halt(1'b0);
    @(posedge clock_i);
    #1;
    brk = 1'b1;
    @(posedge clock_i);
    #1;
    brk = 1'b0;
    wait_halt(1'b1);
    acc(1'b1, DRTA_HCSR_ADDR, KEY | 32'h1);
    wait_halt(1'b0);
    ext = 1'b1;
    wait_halt(1'b1);
    ext = 1'b0;
    finish_test;
  end
endmodule // drta_top_tb
